// ### verification/ocr_link_props.sv
// link checker: output states against controller values
`timescale 1ns/10ps
`default_nettype none
`include "ocr_defines.svh"
module ocr_link_props #(
  parameter int L = 2,  // plain link output
  parameter int H = 3,  // output on module 1
  parameter int V = 4   // inverted link output
) (
  input wire logic                    sys_clk,     // system clock
  input wire logic                    rst_b,       // reset, active low
  input wire logic [`OCR_NUM_OUT-1:0] static_val,  // controller values
  input wire logic [`OCR_NUM_HCM-1:0] hyst_en,     // module enables
  input wire logic [`OCR_NUM_OUT-1:0] out_state    // reported states
);
  // all checks in the system clock domain
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  a_reset_clear: assert property ($rose(rst_b) |-> out_state == '0 && static_val == '0)
    else $error("state not clear after reset");
  a_link_follow: assert property (out_state[L] == $past(static_val[L], 2))
    else $error("link output wrong");
  a_link_invert: assert property ($past(rst_b, 2) |-> out_state[V] != $past(static_val[V], 2))
    else $error("inverted output wrong");
  a_hcm_static: assert property (!$past(hyst_en[0], 2) |-> out_state[H] == $past(static_val[H], 2))
    else $error("static mux path wrong");
  a_link_steady: assert property (static_val[L] [*3] |=> ##1 out_state[L])
    else $error("steady link value lost");
  a_hcm_rise: assert property ($rose(static_val[H]) && !hyst_en[0] |-> ##2 out_state[H])
    else $error("static value not passed");
  a_invert_fall: assert property ($rose(static_val[V]) |-> ##2 $fell(out_state[V]))
    else $error("inverted edge missing");
  a_link_drop: assert property ($fell(static_val[L]) |-> ##1 out_state[L] ##1 !out_state[L])
    else $error("link fall timing wrong");
endmodule // ocr_link_props
`default_nettype wire

// ### verification/output_control_routing_test.sv
// bench: both ends joined over the link, random direct and hysteretic traffic
`timescale 1ns/10ps
`default_nettype none
`include "ocr_defines.svh"
module output_control_routing_test import ocr_pkg::*;;
  logic            sys_clk = 1'b0;
  logic            rst_b = 1'b0;
  logic [5:0]      usr_static, usr_out_state, i2c_ctrl, gpin, cfg_invert, mon;
  logic [3:0]      usr_hyst_en, cfg_pwm_en, hv_on, pwm_gate;
  logic [2:0]      usr_cmp_sel, usr_trip_sel, cfg_trip_fix;
  logic            fvc_a, fvc_b, fast_cur1, fast_hvcur, cfg_trip_dyn;
  logic [7:0]      hvcur_trip_cmp;
  logic [5:0][3:0] cfg_route;
  logic [3:0][2:0] cfg_static_sel;
  logic [1:0]      gp_o, gp_oe;
  logic [17:0]     e_v;
  logic [17:0]     exp_q[$];
  int              mismatches = 0;
  int              total_checks = 0;
  int              cycles = 0;
  event            seen;

  ocr_link_if link_bus ();
  ocr_host i_ocr_host (.sys_clk, .rst_b, .link(link_bus), .usr_static, .usr_hyst_en,
    .usr_cmp_sel, .usr_trip_sel, .usr_out_state);
  ocr_device i_ocr_device (.sys_clk, .rst_b, .link(link_bus), .i2c_ctrl, .gpin, .fvc_a,
    .fvc_b, .fast_cur1, .fast_hvcur, .hvcur_trip_cmp, .cur1_cmp_a(mon[0]),
    .cur1_cmp_b(mon[1]), .fifth_voltage_monitor_cmp_a(mon[2]), .fifth_voltage_monitor_cmp_b(mon[3]), .sixth_voltage_monitor_cmp_a(mon[4]),
    .sixth_voltage_monitor_cmp_b(mon[5]), .cfg_route, .cfg_invert, .cfg_pwm_en, .cfg_trip_dyn, .cfg_trip_fix,
    .cfg_static_sel, .gp_o, .gp_oe, .hv_on, .pwm_gate);
  ocr_link_props i_props (.sys_clk, .rst_b, .static_val(link_bus.static_val),
    .hyst_en(link_bus.hyst_en), .out_state(link_bus.out_state));

  // clock
  initial forever #2.5 sys_clk = ~sys_clk;

  task automatic check(input logic [17:0] seen_v, input logic [17:0] exp_v);
    total_checks++;
    if (seen_v !== exp_v) begin
      mismatches++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen_v, exp_v);
    end
  endtask

  task automatic final_report;
    $display("checks=%0d mismatches=%0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // expected states: modules, routing, polarity, output stages
  function automatic logic [17:0] model();
    logic [3:0]  m;
    logic [11:0] d;
    logic [5:0]  p;
    logic        c;
    for (int h = 0; h < 4; h++) begin
      c = (h == 0) ? hvcur_trip_cmp[cfg_trip_dyn ? usr_trip_sel : cfg_trip_fix]
                   : mon[(2 * h + 4) % 6 + int'(usr_cmp_sel[(h + 2) % 3])];
      m[h] = usr_hyst_en[h] ? ~c : (cfg_static_sel[h] < 3'h6 ? usr_static[cfg_static_sel[h]]
                                                             : 1'b0);
    end
    for (int o = 0; o < 6; o++) begin
      d = {fast_hvcur, fast_cur1, fvc_b, fvc_a, gpin, i2c_ctrl[o], usr_static[o]};
      p[o] = (cfg_route[o] > 4'hb ? m[cfg_route[o][1:0]] : d[cfg_route[o]]) ^ cfg_invert[o];
    end
    return {p, 2'b00, ~p[1:0], p[5:2] & ~cfg_pwm_en, p[5:2] & cfg_pwm_en};
  endfunction

  // random levels on every link and direct input
  task automatic rnd();
    {usr_static, i2c_ctrl, gpin} = 18'($urandom);
    {usr_hyst_en, usr_cmp_sel, usr_trip_sel, fvc_a, fvc_b, fast_cur1, fast_hvcur} = 14'($urandom);
    {hvcur_trip_cmp, mon} = 14'($urandom);
  endtask

  // new configuration under reset, reset levels noted
  task automatic restart(input logic [3:0] code);
    rst_b = 1'b0;
    cfg_route = {4'($urandom), 4'h0, 4'hc, 4'h0, 4'hf - code, code};
    cfg_invert = {1'($urandom), 3'b100, 2'($urandom)};
    cfg_pwm_en = {1'($urandom), 1'b1, 1'($urandom), 1'b0};
    {cfg_trip_dyn, cfg_trip_fix} = 4'($urandom);
    cfg_static_sel = {9'($urandom), 3'h3};
    repeat (5) @(negedge sys_clk);
    exp_q.push_back(18'h00300);
    ->seen;
    rst_b = 1'b1;
  endtask

  task automatic step();
    @(negedge sys_clk);
    rnd();
    repeat (4) @(negedge sys_clk);
    exp_q.push_back(model());
    ->seen;
  endtask

  // watcher: oldest note against the outputs
  always @(seen) begin
    e_v = exp_q.pop_front();
    check({usr_out_state, gp_o, gp_oe, hv_on, pwm_gate}, e_v);
  end

  // hang guard
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 2000) begin
      mismatches++;
      final_report();
    end
  end

  // every routing code on both pins, random traffic
  initial begin
    void'($urandom(32'ha17c));
    rnd();
    for (int c = 0; c < 16; c++) begin
      restart(4'(c));
      repeat (6) step();
    end
    final_report();
  end
endmodule // output_control_routing_test
`default_nettype wire

// ### verilog/ocr_defines.svh
// constants of the output control routing block
`ifndef OCR_DEFINES_SVH
`define OCR_DEFINES_SVH

// controlled outputs: two general-purpose pins, then four high-voltage outputs
`define OCR_NUM_OUT    6
`define OCR_NUM_GP     2
`define OCR_NUM_HV     4
`define OCR_IDX_GP2    0
`define OCR_IDX_GP3    1
`define OCR_IDX_HV0    2
`define OCR_NUM_HCM    4
`define OCR_NUM_DIR    12
`define OCR_NUM_GPIN   6

// routing select codes (4 bits)
`define OCR_RT_W       4
`define OCR_RT_LINK    4'h0
`define OCR_RT_I2C     4'h1
`define OCR_RT_GPIN0   4'h2
`define OCR_RT_VCA     4'h8
`define OCR_RT_VCB     4'h9
`define OCR_RT_CUR1    4'ha
`define OCR_RT_HVCUR   4'hb
`define OCR_RT_HCM0    4'hc

// trip point select of the first hysteretic module
`define OCR_TRIP_W     3
`define OCR_NUM_TRIP   8
// static control mux select width
`define OCR_SSEL_W     3

// reset level of every output but the pin pull-low enables, and of held link values
`define OCR_RST_BIT    1'b0
`define OCR_PIN_LOW    1'b0

`endif

// ### verilog/ocr_device.sv
// device end: output control routing for two pins and four high-voltage outputs
//
// Operation
// - controls pins 2, 3 and four high-voltage outputs
// - each output direct or hysteretic controlled
// - direct sources: register, pins, fast comparators
// - controller drives any output over link
// - hysteretic output follows feedback against set-point
// - controller selectable as feedback source
// - routing mux: twelve direct or four modules
// - polarity stage passes or inverts selection
// - pulse-width mode: polarity gates generator, else switch
// - pins 2, 3 follow polarity stage output
// - module 1 fixed or dynamic trip point
// - module 1 inverts filtered current comparator
// - hysteretic enable picks comparator or static mux
// - static mux normally picks own output bit
// - modules 2..4 select comparator A or B
// - modules 2..4 invert comparator mux output
// - module monitors: current one, voltage five, six
// - pins 5..10 reach routing unregistered
`timescale 1ns/10ps
`default_nettype none
`include "ocr_defines.svh"

module ocr_device
  import ocr_pkg::*;
(
  input  wire logic                    sys_clk,          // system clock
  input  wire logic                    rst_b,            // async reset, active low
  ocr_link_if.dev                      link,             // expander link
  // direct sources
  input  wire logic [`OCR_NUM_OUT-1:0] i2c_ctrl,         // register bit per output
  input  wire logic [`OCR_NUM_GPIN-1:0] gpin,            // pins 5..10 as inputs
  input  wire logic                    fvc_a,            // fast voltage comparator a
  input  wire logic                    fvc_b,            // fast voltage comparator b
  input  wire logic                    fast_cur1,        // fast first current comparator
  input  wire logic                    fast_hvcur,       // fast high-voltage current comp
  // glitch-filtered monitor comparators
  input  wire logic [`OCR_NUM_TRIP-1:0] hvcur_trip_cmp,  // hv current, one per trip point
  input  wire logic                    cur1_cmp_a,       // first current monitor, comp a
  input  wire logic                    cur1_cmp_b,       // first current monitor, comp b
  input  wire logic                    fifth_voltage_monitor_cmp_a,      // fifth voltage monitor, comp a
  input  wire logic                    fifth_voltage_monitor_cmp_b,      // fifth voltage monitor, comp b
  input  wire logic                    sixth_voltage_monitor_cmp_a,      // sixth voltage monitor, comp a
  input  wire logic                    sixth_voltage_monitor_cmp_b,      // sixth voltage monitor, comp b
  // configuration, static during operation
  input  wire logic [`OCR_NUM_OUT-1:0][`OCR_RT_W-1:0] cfg_route,     // routing select
  input  wire logic [`OCR_NUM_OUT-1:0]                cfg_invert,    // polarity invert
  input  wire logic [`OCR_NUM_HV-1:0]                 cfg_pwm_en,    // pulse-width mode
  input  wire logic                                   cfg_trip_dyn,  // module 1 dynamic trip
  input  wire logic [`OCR_TRIP_W-1:0]                 cfg_trip_fix,  // module 1 fixed trip
  input  wire logic [`OCR_NUM_HCM-1:0][`OCR_SSEL_W-1:0] cfg_static_sel, // static mux select
  // outputs
  output logic      [`OCR_NUM_GP-1:0]  gp_o,             // pins 2, 3 drive value (low)
  output logic      [`OCR_NUM_GP-1:0]  gp_oe,            // pins 2, 3 pull-low enable
  output logic      [`OCR_NUM_HV-1:0]  hv_on,            // high-voltage output switch
  output logic      [`OCR_NUM_HV-1:0]  pwm_gate          // pulse-width stage enable
);

  ocr_dev_state_t st_r;
  ocr_dev_state_t st_nxt;

  // combinational nets of the routing path
  logic [`OCR_NUM_HCM-1:0] hcm_out;
  logic [`OCR_NUM_HCM-1:0] hcm_cmp;
  logic [`OCR_NUM_OUT-1:0] pol_out;
  logic [`OCR_TRIP_W-1:0]  trip_pick;
  logic [`OCR_NUM_HCM-1:0] hcm_static;
  logic [`OCR_NUM_DIR-1:0] dir_shared;
  logic                    cur1_pick;
  logic                    fifth_voltage_monitor_pick;
  logic                    sixth_voltage_monitor_pick;

  // module 1 trip point: fixed configuration or controller choice
  always_comb begin
    if (cfg_trip_dyn) begin
      trip_pick = st_r.lk_trip;
    end else begin
      trip_pick = cfg_trip_fix;
    end
  end

  // module 2: first current monitor, comparator a or b
  always_comb begin
    if (st_r.lk_cmp_sel[0]) begin
      cur1_pick = cur1_cmp_b;
    end else begin
      cur1_pick = cur1_cmp_a;
    end
  end

  // module 3: fifth voltage monitor, comparator a or b
  always_comb begin
    if (st_r.lk_cmp_sel[1]) begin
      fifth_voltage_monitor_pick = fifth_voltage_monitor_cmp_b;
    end else begin
      fifth_voltage_monitor_pick = fifth_voltage_monitor_cmp_a;
    end
  end

  // module 4: sixth voltage monitor, comparator a or b
  always_comb begin
    if (st_r.lk_cmp_sel[2]) begin
      sixth_voltage_monitor_pick = sixth_voltage_monitor_cmp_b;
    end else begin
      sixth_voltage_monitor_pick = sixth_voltage_monitor_cmp_a;
    end
  end

  // feedback per module, inverted so a reading below set-point turns on
  always_comb begin
    hcm_cmp[0] = ~hvcur_trip_cmp[trip_pick];
    hcm_cmp[1] = ~cur1_pick;
    hcm_cmp[2] = ~fifth_voltage_monitor_pick;
    hcm_cmp[3] = ~sixth_voltage_monitor_pick;
  end

  // static control mux per module, inputs all from the link
  always_comb begin
    for (int h = 0; h < `OCR_NUM_HCM; h++) begin
      hcm_static[h] = ocr_static(cfg_static_sel[h], st_r.lk_static);
    end
  end

  // hysteretic enable mux: comparator path or static control mux
  always_comb begin
    for (int h = 0; h < `OCR_NUM_HCM; h++) begin
      if (st_r.lk_hyst_en[h]) begin
        hcm_out[h] = hcm_cmp[h];
      end else begin
        hcm_out[h] = hcm_static[h];
      end
    end
  end

  // direct sources common to every output, unregistered fast path
  always_comb begin
    dir_shared                = '0;
    dir_shared[`OCR_RT_GPIN0 +: `OCR_NUM_GPIN] = gpin;
    dir_shared[`OCR_RT_VCA]   = fvc_a;
    dir_shared[`OCR_RT_VCB]   = fvc_b;
    dir_shared[`OCR_RT_CUR1]  = fast_cur1;
    dir_shared[`OCR_RT_HVCUR] = fast_hvcur;
  end

  // routing mux and polarity stage, one per controlled output
  always_comb begin
    logic [`OCR_NUM_DIR-1:0] dir;
    dir = '0;
    for (int o = 0; o < `OCR_NUM_OUT; o++) begin
      dir                = dir_shared;
      dir[`OCR_RT_LINK]  = st_r.lk_static[o];
      dir[`OCR_RT_I2C]   = i2c_ctrl[o];
      pol_out[o] = ocr_route(cfg_route[o], dir, hcm_out) ^ cfg_invert[o];
    end
  end

  // next state: hold link values, drive outputs from polarity stage
  always_comb begin
    st_nxt            = st_r;
    // link values held: one cycle of normal latency
    st_nxt.lk_static  = link.static_val;
    st_nxt.lk_hyst_en = link.hyst_en;
    st_nxt.lk_cmp_sel = link.cmp_sel;
    st_nxt.lk_trip    = link.trip_sel;
    // polarity results reported back over the link
    st_nxt.out_state  = pol_out;
    // pins 2 and 3: on releases the pin, off pulls it low
    st_nxt.gp_oe[0]   = ~pol_out[`OCR_IDX_GP2];
    st_nxt.gp_oe[1]   = ~pol_out[`OCR_IDX_GP3];
    // high-voltage: pulse-width stage gate or direct switch
    for (int v = 0; v < `OCR_NUM_HV; v++) begin
      if (cfg_pwm_en[v]) begin
        st_nxt.pwm_gate[v] = pol_out[`OCR_IDX_HV0 + v];
        st_nxt.hv_sw[v]    = `OCR_RST_BIT;
      end else begin
        st_nxt.pwm_gate[v] = `OCR_RST_BIT;
        st_nxt.hv_sw[v]    = pol_out[`OCR_IDX_HV0 + v];
      end
    end
  end

  // state register; reset leaves every output off
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      st_r       <= '0;
      st_r.gp_oe <= '1;  // pins pulled low while off
    end else begin
      st_r <= st_nxt;
    end
  end

  // pull-low enables from flops; open-drain pins only ever drive low
  assign gp_o           = {`OCR_NUM_GP{`OCR_PIN_LOW}};
  assign gp_oe          = st_r.gp_oe;

  // high-voltage stage and reported states
  assign hv_on          = st_r.hv_sw;
  assign pwm_gate       = st_r.pwm_gate;
  assign link.out_state = st_r.out_state;

endmodule // ocr_device
`default_nettype wire

// ### verilog/ocr_host.sv
// controller end: drives static values, enables and selects onto the link
`timescale 1ns/10ps
`default_nettype none
`include "ocr_defines.svh"

module ocr_host
  import ocr_pkg::*;
(
  input  wire logic                    sys_clk,        // system clock
  input  wire logic                    rst_b,          // async reset, active low
  ocr_link_if.host                     link,           // expander link
  input  wire logic [`OCR_NUM_OUT-1:0] usr_static,     // static value per output
  input  wire logic [`OCR_NUM_HCM-1:0] usr_hyst_en,    // hysteretic enable per module
  input  wire logic [`OCR_NUM_HCM-2:0] usr_cmp_sel,    // comparator B select
  input  wire logic [`OCR_TRIP_W-1:0]  usr_trip_sel,   // dynamic trip point
  output logic      [`OCR_NUM_OUT-1:0] usr_out_state   // reported output states
);

  ocr_host_state_t st_r;
  ocr_host_state_t st_nxt;

  // capture user controls for the link each cycle
  always_comb begin
    st_nxt            = st_r;
    st_nxt.static_val = usr_static;
    st_nxt.hyst_en    = usr_hyst_en;
    st_nxt.cmp_sel    = usr_cmp_sel;
    st_nxt.trip_sel   = usr_trip_sel;
    st_nxt.out_state  = link.out_state;
  end

  // state register
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // link and user outputs straight from flops
  assign link.static_val = st_r.static_val;
  assign link.hyst_en    = st_r.hyst_en;
  assign link.cmp_sel    = st_r.cmp_sel;
  assign link.trip_sel   = st_r.trip_sel;
  assign usr_out_state   = st_r.out_state;

endmodule // ocr_host
`default_nettype wire

// ### verilog/ocr_link_if.sv
// expander link between the device end and the controller end
`timescale 1ns/10ps
`default_nettype none
`include "ocr_defines.svh"

interface ocr_link_if;
  logic [`OCR_NUM_OUT-1:0] static_val;  // controller static value per output
  logic [`OCR_NUM_HCM-1:0] hyst_en;     // hysteretic enable per module
  logic [`OCR_NUM_HCM-2:0] cmp_sel;     // comparator B select, modules 2..4
  logic [`OCR_TRIP_W-1:0]  trip_sel;    // dynamic trip point of module 1
  logic [`OCR_NUM_OUT-1:0] out_state;   // output states back to controller

  modport dev (input static_val, input hyst_en, input cmp_sel, input trip_sel,
               output out_state);
  modport host (output static_val, output hyst_en, output cmp_sel, output trip_sel,
                input out_state);
endinterface
`default_nettype wire

// ### verilog/ocr_pkg.sv
// types and shared functions of the output control routing block
`include "ocr_defines.svh"

package ocr_pkg;

  // state of the device end
  typedef struct packed {
    logic [`OCR_NUM_OUT-1:0] lk_static;   // link static values, held
    logic [`OCR_NUM_HCM-1:0] lk_hyst_en;  // link hysteretic enables, held
    logic [`OCR_NUM_HCM-2:0] lk_cmp_sel;  // link comparator selects, held
    logic [`OCR_TRIP_W-1:0]  lk_trip;     // link dynamic trip point, held
    logic [`OCR_NUM_GP-1:0]  gp_oe;       // pin pull-low enables
    logic [`OCR_NUM_HV-1:0]  hv_sw;       // high-voltage direct switches
    logic [`OCR_NUM_HV-1:0]  pwm_gate;    // pulse-width stage enables
    logic [`OCR_NUM_OUT-1:0] out_state;   // output states reported back
  } ocr_dev_state_t;

  // state of the controller end
  typedef struct packed {
    logic [`OCR_NUM_OUT-1:0] static_val;
    logic [`OCR_NUM_HCM-1:0] hyst_en;
    logic [`OCR_NUM_HCM-2:0] cmp_sel;
    logic [`OCR_TRIP_W-1:0]  trip_sel;
    logic [`OCR_NUM_OUT-1:0] out_state;
  } ocr_host_state_t;

  // routing mux: one of twelve direct signals or one of four module outputs
  function automatic logic ocr_route(input logic [`OCR_RT_W-1:0]   sel,
                                     input logic [`OCR_NUM_DIR-1:0] dir,
                                     input logic [`OCR_NUM_HCM-1:0] hysteretic_control_module);
    if (sel >= `OCR_RT_HCM0) begin
      return hysteretic_control_module[sel[1:0]];
    end
    return dir[sel];
  endfunction

  // static control mux: picks one link static bit, out of range reads low
  function automatic logic ocr_static(input logic [`OCR_SSEL_W-1:0]  sel,
                                      input logic [`OCR_NUM_OUT-1:0] val);
    if (sel < `OCR_SSEL_W'(`OCR_NUM_OUT)) begin
      return val[sel];
    end
    return `OCR_RST_BIT;
  endfunction

endpackage
